// File: hdl/albi_pkg.sv
package albi_pkg;
	localparam int CLK_HZ         = 50_000_000;
	localparam int SER_BAUD       = 9600;
	localparam int SER_DIV        = CLK_HZ / SER_BAUD;
	localparam int FRAME_MS       = 50;
	localparam int FRAME_CYC      = CLK_HZ / 1000 * FRAME_MS;
	localparam int FRAMES_PER_SEC = 1000 / FRAME_MS;
	localparam int FRAMES_200MS   = 200 / FRAME_MS;
	localparam int A429_HI_BPS    = 100_000;
	localparam int A429_LO_BPS    = 12_500;
	localparam int BIT_HI_CYC     = CLK_HZ / A429_HI_BPS;
	localparam int BIT_LO_CYC     = CLK_HZ / A429_LO_BPS;
	localparam int WORD_BITS      = 32;
	localparam int GAP_BITS       = 4;

	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STAT     = 8'h04;
	localparam logic [7:0] REG_SER_DATA = 8'h08;
	localparam logic [7:0] REG_SER_STAT = 8'h0c;
	localparam logic [7:0] REG_AIR_BASE = 8'h10;
	localparam logic [7:0] REG_TXW_BASE = 8'h40;
	localparam logic [7:0] REG_RXP_BASE = 8'h80;

	localparam int CTRL_W        = 13;
	localparam int CTRL_PROF_LSB = 0;
	localparam int CTRL_ADC2     = 2;
	localparam int CTRL_DEGR     = 3;
	localparam int CTRL_CPLR     = 4;
	localparam int CTRL_NAVINST  = 5;
	localparam int CTRL_RXHI_LSB = 6;
	localparam int CTRL_TXHI     = 10;
	localparam int CTRL_BACKCRS  = 11;
	localparam int CTRL_ALTENG   = 12;
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

	localparam logic [1:0] PROF_STD   = 2'h0;
	localparam logic [1:0] PROF_THIRD = 2'h2;
	localparam logic [7:0] STX        = 8'h02;
	localparam logic [7:0] ETX        = 8'h03;
	localparam logic [7:0] ITEM_TAG   = 8'h41;
	localparam logic [15:0] TURN_INVALID = 16'h8000;
	localparam int AIR_ITEMS = 5;
	localparam logic [2:0] ITEM_TURN = 3'h2;

	// received labels, data field offsets count from word bit 9
	localparam logic [7:0] LBL_HDR  = 8'h3c;
	localparam logic [7:0] LBL_MODE = 8'h3d;
	localparam logic [7:0] LBL_SRC  = 8'h40;
	localparam logic [7:0] LBL_TOFR = 8'hbd;
	localparam logic [7:0] LBL_FREQ = 8'h1c;
	localparam int RX_SLOTS    = 16;
	localparam int RX_NAV_BASE = 12;
	localparam logic [15:0][7:0] RX_LBL = {8'h92, 8'h7c, 8'h7b, 8'h1c, 8'hd7, 8'hd6, 8'hcb, 8'hca,
		8'haa, 8'ha9, 8'h51, 8'h67, 8'h4f, 8'h4e, 8'h4d, 8'h4c};
	localparam int B_HOLD = 0;
	localparam int B_SRC_LO = 3;
	localparam int B_SRC_HI = 4;
	localparam int B_LOCEN = 5;
	localparam int B_GPSNAV = 6;
	localparam int B_BACKCRS = 7;
	localparam int B_TO = 14;
	localparam int B_FROM = 15;
	localparam int B_ALTENG = 19;

	// transmit set, 50 ms labels first so their slots never move
	localparam int TX_N = 12;
	localparam int TX_IDX_DISC = 4;
	localparam logic [11:0][7:0] TX_LBL = {8'hec, 8'he8, 8'h84, 8'h83, 8'h40, 8'hd0, 8'hbf, 8'hb1,
		8'h9d, 8'h7c, 8'h7b, 8'h45};
	// period class per label: 0 = 50 ms, 1 = 200 ms, 2 = 1000 ms
	localparam logic [11:0][1:0] TX_CLS = 24'ha54000;
	localparam logic [11:0] TX_BASIC = 12'h3c0;

	typedef enum logic [1:0] {
		UP_IDLE = 2'b00,
		UP_HEAD = 2'b01,
		UP_BODY = 2'b10,
		UP_TAIL = 2'b11
	} albi_pkt_e;
endpackage

// File: hdl/albi_label_bus.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module albi_label_bus #(
	parameter int SER_DIV_P   = albi_pkg::SER_DIV,
	parameter int FRAME_CYC_P = albi_pkg::FRAME_CYC
) (
	input  wire logic        clk,      // 50 MHz
	input  wire logic        rst_b,    // sync reset
	input  wire logic [7:0]  regAddr,  // byte address
	input  wire logic [31:0] regWdata, // write data
	input  wire logic        regWr,    // write strobe
	input  wire logic        regRd,    // read strobe
	output logic      [31:0] regRdata, // read data, next cycle
	input  wire logic        serRx,    // serial gps line
	output logic             serTx,    // serial air data line
	input  wire logic [3:0]  rxHi,     // 429 inputs, high leg
	input  wire logic [3:0]  rxLo,     // 429 inputs, low leg
	output logic             txHi,     // 429 output, high leg
	output logic             txLo      // 429 output, low leg
);
	import albi_pkg::*;

	typedef struct packed {
		logic [CTRL_W-1:0]  ctrl;
		logic [4:0][15:0]   air;
		logic [11:0][22:0]  txw;
		logic [15:0][22:0]  rxp;
		logic               holdMode, toFlag, fromFlag, devSrcNav, locEnergize;
		logic [7:0]         hdrCnt;
		logic [3:0][1:0]    pinS1, pinS2;
		logic [3:0][31:0]   rxSh;
		logic [3:0][5:0]    rxCnt;
		logic [3:0][12:0]   rxTmr;
		logic [3:0]         rxLvl, rxRdy;
		logic [3:0][31:0]   rxWord;
		logic               serS1, serS2;
		logic [15:0]        urTmr;
		logic [3:0]         urBit;
		logic [7:0]         urSh;
		logic               urBusy, inPkt;
		logic [1:0][7:0]    fifo;
		logic [1:0]         fifoCnt;
		logic               fifoRd, overrun;
		logic [7:0]         pktCnt;
		logic [15:0]        utTmr;
		logic [3:0]         utBit;
		logic [9:0]         utSh;
		logic               utBusy;
		albi_pkt_e          upSt;
		logic [2:0]         upItem;
		logic [1:0]         upPart;
		logic               serTxInv;
		logic [21:0]        frmTmr;
		logic [4:0]         frame;
		logic [11:0]        due;
		logic [31:0]        atSh;
		logic [5:0]         atBit;
		logic [12:0]        atTmr;
		logic               atBusy, txHi, txLo;
		logic [31:0]        rdata;
	} albi_state_s;

	albi_state_s q;
	albi_state_s d;

	always_comb begin
		logic [12:0] bitCyc;
		logic [1:0]  sel;
		logic [31:0] w;
		logic [7:0]  lbl, inByte, outByte;
		logic [22:0] data;
		logic [15:0] val;
		logic [2:0]  nxt;
		logic        found, isNav, gotByte, keep, pushOk, pop, tick, ldByte;
		{bitCyc, sel, w, lbl, inByte, outByte, data, val, nxt} = '0;
		{found, isNav, gotByte, keep, pushOk, pop, tick, ldByte} = '0;
		d = q;

		// 429 receivers: a bit is taken on each null-to-level change
		for (int p = 0; p < 4; p++) begin
			bitCyc = q.ctrl[CTRL_RXHI_LSB+p] ? 13'(BIT_HI_CYC) : 13'(BIT_LO_CYC);
			d.pinS1[p] = {rxHi[p], rxLo[p]};
			d.pinS2[p] = q.pinS1[p];
			if (q.pinS2[p][1] ^ q.pinS2[p][0]) begin
				d.rxTmr[p] = '0;
				if (!q.rxLvl[p]) begin
					d.rxLvl[p] = 1'b1;
					d.rxSh[p] = {q.pinS2[p][1], q.rxSh[p][31:1]};
					d.rxCnt[p] = q.rxCnt[p] + 6'd1;
					if (q.rxCnt[p] == 6'(WORD_BITS - 1)) begin
						d.rxCnt[p] = '0;
						d.rxWord[p] = {q.pinS2[p][1], q.rxSh[p][31:1]};
						d.rxRdy[p] = 1'b1;
					end
				end
			end else begin
				d.rxLvl[p] = 1'b0;
				if (q.rxTmr[p] != 13'h1fff)
					d.rxTmr[p] = q.rxTmr[p] + 13'd1;
				// a null longer than two bits is a word gap; resyncs a torn word
				if (q.rxTmr[p] > {bitCyc[11:0], 1'b0})
					d.rxCnt[p] = '0;
			end
		end

		// one finished word decoded per cycle; words are far apart, none waits long
		for (int p = 3; p >= 0; p--) begin
			if (q.rxRdy[p]) begin
				found = 1'b1;
				sel = 2'(p);
			end
		end
		w = q.rxWord[sel];
		for (int i = 0; i < 8; i++)
			lbl[7-i] = w[i];
		data = w[30:8];
		isNav = sel[1];
		if (found) begin
			d.rxRdy[sel] = 1'b0;
			// bad parity or unknown label leaves state alone
			if (^w) begin
				for (int s = 0; s < RX_SLOTS; s++)
					if (RX_LBL[s] == lbl && ((s >= RX_NAV_BASE) == isNav))
						d.rxp[s] = data;
				if (!isNav) begin
					if (lbl == LBL_HDR)
						d.hdrCnt = q.hdrCnt + 8'd1;
					if (lbl == LBL_MODE)
						d.holdMode = data[B_HOLD];
					if (lbl == LBL_SRC && q.ctrl[CTRL_NAVINST] && data[B_SRC_HI] != data[B_SRC_LO])
						d.devSrcNav = data[B_SRC_HI];
					if (lbl == LBL_TOFR) begin
						d.toFlag = data[B_TO];
						d.fromFlag = data[B_FROM];
					end
				end else if (lbl == LBL_FREQ) begin
					d.locEnergize = data[B_LOCEN];
				end
			end
		end

		// serial receiver, sampled mid-bit
		d.serS1 = serRx;
		d.serS2 = q.serS1;
		if (!q.urBusy) begin
			if (!q.serS2) begin
				d.urBusy = 1'b1;
				d.urTmr = 16'(SER_DIV_P / 2);
				d.urBit = '0;
			end
		end else if (q.urTmr != '0) begin
			d.urTmr = q.urTmr - 16'd1;
		end else begin
			d.urTmr = 16'(SER_DIV_P - 1);
			d.urBit = q.urBit + 4'd1;
			if (q.urBit == 4'd0 && q.serS2)
				d.urBusy = 1'b0;
			else if (q.urBit >= 4'd1 && q.urBit <= 4'd8)
				d.urSh = {q.serS2, q.urSh[7:1]};
			else if (q.urBit == 4'd9) begin
				d.urBusy = 1'b0;
				gotByte = q.serS2;
			end
		end

		// profile: standard is 7-bit framed, enhanced 8-bit framed, third passes all bytes
		inByte = (q.ctrl[1:0] == PROF_STD) ? {1'b0, q.urSh[6:0]} : q.urSh;
		if (gotByte) begin
			keep = q.inPkt || q.ctrl[1:0] == PROF_THIRD;
			if (q.urSh == STX)
				d.inPkt = 1'b1;
			if (q.urSh == ETX) begin
				d.inPkt = 1'b0;
				if (keep)
					d.pktCnt = q.pktCnt + 8'd1;
			end
		end
		// a byte arriving to a full buffer is lost and flagged; set beats clear
		pop = regRd && regAddr == REG_SER_DATA && q.fifoCnt != 2'd0;
		pushOk = keep && q.fifoCnt != 2'd2;
		if (pushOk)
			d.fifo[q.fifoRd ^ q.fifoCnt[0]] = inByte;
		d.fifoCnt = q.fifoCnt + {1'b0, pushOk} - {1'b0, pop};
		d.fifoRd = q.fifoRd ^ pop;
		d.overrun = (q.overrun && !(regRd && regAddr == REG_SER_STAT)) || (keep && !pushOk);

		// 50 ms frame clock drives both transmitters
		tick = q.frmTmr == 22'(FRAME_CYC_P - 1);
		d.frmTmr = tick ? '0 : q.frmTmr + 22'd1;
		if (tick)
			d.frame = (q.frame == 5'(FRAMES_PER_SEC - 1)) ? '0 : q.frame + 5'd1;

		// serial air data packet once a second
		if (tick && d.frame == '0 && q.upSt == UP_IDLE)
			d.upSt = UP_HEAD;
		val = q.air[q.upItem];
		// turn rate invalid in degraded mode
		if (q.upItem == ITEM_TURN && q.ctrl[CTRL_DEGR])
			val = TURN_INVALID;
		nxt = q.upItem + 3'd1;
		if (nxt == ITEM_TURN && q.ctrl[CTRL_ADC2])
			nxt = nxt + 3'd1;
		if (!q.utBusy) begin
			unique case (q.upSt)
				UP_IDLE: ;
				UP_HEAD: begin
					ldByte = 1'b1;
					outByte = STX;
					d.upSt = UP_BODY;
					d.upItem = '0;
					d.upPart = '0;
				end
				UP_BODY: begin
					ldByte = 1'b1;
					outByte = (q.upPart == 2'd0) ? ITEM_TAG + 8'(q.upItem) :
						(q.upPart == 2'd1) ? val[15:8] : val[7:0];
					d.upPart = (q.upPart == 2'd2) ? 2'd0 : q.upPart + 2'd1;
					if (q.upPart == 2'd2) begin
						d.upItem = nxt;
						if (nxt >= 3'(AIR_ITEMS))
							d.upSt = UP_TAIL;
					end
				end
				UP_TAIL: begin
					ldByte = 1'b1;
					outByte = ETX;
					d.upSt = UP_IDLE;
				end
			endcase
		end
		if (ldByte) begin
			d.utSh = {1'b1, outByte, 1'b0};
			d.utBusy = 1'b1;
			d.utBit = '0;
			d.utTmr = '0;
		end else if (q.utBusy) begin
			if (q.utTmr == 16'(SER_DIV_P - 1)) begin
				d.utTmr = '0;
				d.utSh = {1'b1, q.utSh[9:1]};
				d.utBit = q.utBit + 4'd1;
				if (q.utBit == 4'd9)
					d.utBusy = 1'b0;
			end else begin
				d.utTmr = q.utTmr + 16'd1;
			end
		end
		d.serTxInv = q.utBusy && !q.utSh[0];

		// 429 transmitter; lowest due index first keeps each label at a fixed offset
		bitCyc = q.ctrl[CTRL_TXHI] ? 13'(BIT_HI_CYC) : 13'(BIT_LO_CYC);
		if (!q.atBusy) begin
			for (int k = TX_N - 1; k >= 0; k--) begin
				if (q.due[k]) begin
					data = q.txw[k];
					if (k == TX_IDX_DISC) begin
						data[B_LOCEN] = q.locEnergize;
						data[B_GPSNAV] = q.devSrcNav;
						data[B_BACKCRS] = q.ctrl[CTRL_BACKCRS];
						data[B_ALTENG] = q.ctrl[CTRL_ALTENG];
					end
					for (int i = 0; i < 8; i++)
						w[i] = TX_LBL[k][7-i];
					w[30:8] = data;
					w[31] = ~^w[30:0];
					d.atSh = w;
					d.atBusy = 1'b1;
					d.atBit = '0;
					d.atTmr = '0;
					d.due = q.due & ~(12'h001 << k);
				end
			end
		end else if (q.atTmr < bitCyc - 13'd1) begin
			d.atTmr = q.atTmr + 13'd1;
		end else begin
			d.atTmr = '0;
			d.atBit = q.atBit + 6'd1;
			d.atSh = {1'b0, q.atSh[31:1]};
			if (q.atBit == 6'(WORD_BITS + GAP_BITS - 1))
				d.atBusy = 1'b0;
		end
		d.txHi = q.atBusy && q.atBit < 6'(WORD_BITS) && q.atTmr < {1'b0, bitCyc[12:1]} && q.atSh[0];
		d.txLo = q.atBusy && q.atBit < 6'(WORD_BITS) && q.atTmr < {1'b0, bitCyc[12:1]} && !q.atSh[0];
		// queue labels due in the frame now starting
		if (tick) begin
			for (int k = 0; k < TX_N; k++) begin
				if ((q.ctrl[CTRL_CPLR] || TX_BASIC[k]) && (TX_CLS[k] == 2'd0 ||
					(TX_CLS[k] == 2'd1 && d.frame % 5'(FRAMES_200MS) == 5'd0) ||
					(TX_CLS[k] == 2'd2 && d.frame == 5'd0)))
					d.due[k] = 1'b1;
			end
		end

		// register port
		if (regWr) begin
			if (regAddr == REG_CTRL)
				d.ctrl = regWdata[CTRL_W-1:0];
			for (int i = 0; i < AIR_ITEMS; i++)
				if (regAddr == REG_AIR_BASE + 8'(4 * i))
					d.air[i] = regWdata[15:0];
			for (int k = 0; k < TX_N; k++)
				if (regAddr == REG_TXW_BASE + 8'(4 * k))
					d.txw[k] = regWdata[22:0];
		end
		d.rdata = '0;
		if (regRd) begin
			if (regAddr == REG_CTRL)
				d.rdata = {19'h0, q.ctrl};
			if (regAddr == REG_STAT)
				d.rdata = {16'h0, q.hdrCnt, 3'h0, q.locEnergize, q.devSrcNav, q.fromFlag, q.toFlag, q.holdMode};
			if (regAddr == REG_SER_DATA)
				d.rdata = {23'h0, q.fifoCnt != 2'd0, q.fifo[q.fifoRd]};
			if (regAddr == REG_SER_STAT)
				d.rdata = {21'h0, q.overrun, q.fifoCnt, q.pktCnt};
			for (int i = 0; i < AIR_ITEMS; i++)
				if (regAddr == REG_AIR_BASE + 8'(4 * i))
					d.rdata = {16'h0, q.air[i]};
			for (int k = 0; k < TX_N; k++)
				if (regAddr == REG_TXW_BASE + 8'(4 * k))
					d.rdata = {9'h0, q.txw[k]};
			for (int s = 0; s < RX_SLOTS; s++)
				if (regAddr == REG_RXP_BASE + 8'(4 * s))
					d.rdata = {9'h0, q.rxp[s]};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			{q.serS1, q.serS2} <= 2'b11; // idle line level, no false start after reset
		end else begin
			q <= d;
		end
	end

	assign regRdata = q.rdata;
	assign serTx = ~q.serTxInv;
	assign txHi = q.txHi;
	assign txLo = q.txLo;
endmodule // albi_label_bus

// File: tb/albi_label_bus_asserts.sv
`timescale 1ns/1ps
module albi_label_bus_asserts
	import albi_pkg::*;
#(
	parameter int SER_DIV_P   = 16,
	parameter int FRAME_CYC_P = 20000
) (
	input wire logic        clk,      // clock
	input wire logic        rst_b,    // sync reset
	input wire logic [7:0]  regAddr,  // address
	input wire logic [31:0] regWdata, // write data
	input wire logic        regWr,    // write strobe
	input wire logic        regRd,    // read strobe
	input wire logic [31:0] regRdata, // read data
	input wire logic        serRx,    // serial in
	input wire logic        serTx,    // serial out
	input wire logic [3:0]  rxHi,     // rx high legs
	input wire logic [3:0]  rxLo,     // rx low legs
	input wire logic        txHi,     // tx high leg
	input wire logic        txLo      // tx low leg
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_TX_EXCL: assert property (!(txHi && txLo))
		else $error("both transmit legs high");
	AST_TX_RZ: assert property ($fell(txHi) |-> (!txHi && !txLo) [*8])
		else $error("transmit null half too short");
	AST_SER_LOW: assert property ($fell(serTx) |-> !serTx [*8])
		else $error("serial low level shorter than a bit");
	AST_SER_HIGH: assert property ($rose(serTx) |-> serTx [*8])
		else $error("serial high level shorter than a bit");
	AST_RST_IDLE: assert property ($rose(rst_b) |-> serTx && !txHi && !txLo && regRdata == 32'h0)
		else $error("outputs not idle after reset");
	AST_RD_IDLE: assert property (!regRd |=> regRdata == 32'h0)
		else $error("read data outside read answer cycle");
	AST_CTRL_RB: assert property ((regWr && regAddr == REG_CTRL) ##1 !regWr ##1
		(regRd && regAddr == REG_CTRL) |=> regRdata == ($past(regWdata, 3) & 32'h1fff))
		else $error("control readback mismatch");
	AST_STAT_RSV: assert property (regRd && regAddr == REG_STAT |=> regRdata[31:16] == 16'h0)
		else $error("status upper bits not zero");
	AST_RXP_W: assert property (regRd && regAddr[7] |=> regRdata[31:23] == 9'h0)
		else $error("received field wider than word");
endmodule // albi_label_bus_asserts

bind albi_label_bus albi_label_bus_asserts #(
	.SER_DIV_P  (SER_DIV_P),
	.FRAME_CYC_P(FRAME_CYC_P)
) i_albi_label_bus_asserts (
	.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .serRx(serRx), .serTx(serTx), .rxHi(rxHi), .rxLo(rxLo), .txHi(txHi), .txLo(txLo)
);

// File: tb/albi_far_model.sv
`timescale 1ns/1ps
module albi_far_model #(
	parameter int BIT_CYC = 500,
	parameter int SER_DIV = 16
) (
	input  wire logic       clk,   // bench clock
	output logic      [3:0] rxHi,  // 429 high legs
	output logic      [3:0] rxLo,  // 429 low legs
	output logic            serRx, // serial gps line
	input  wire logic       txHi,  // 429 tx high leg
	input  wire logic       txLo   // 429 tx low leg
);
	initial begin
		rxHi = 4'h0;
		rxLo = 4'h0;
		serRx = 1'b1;
	end

	task automatic sendWord(input logic [1:0] port, input logic [31:0] w);
		@(posedge clk);
		for (int i = 0; i < 32; i++) begin
			rxHi[port] <= w[i];
			rxLo[port] <= ~w[i];
			repeat (BIT_CYC / 2) @(posedge clk);
			rxHi[port] <= 1'b0;
			rxLo[port] <= 1'b0;
			repeat (BIT_CYC / 2) @(posedge clk);
		end
		// null gap of four bits lets the receiver resync its bit count
		repeat (4 * BIT_CYC) @(posedge clk);
	endtask

	// rz word receiver
	// sampled on the falling edge, clear of the edge that launches the legs
	task automatic recvWord(output logic [31:0] w);
		for (int i = 0; i < 32; i++) begin
			@(negedge clk iff (txHi || txLo));
			w[i] = txHi;
			@(negedge clk iff (!txHi && !txLo));
		end
	endtask

	task automatic sendByte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serRx <= f[i];
			repeat (SER_DIV) @(posedge clk);
		end
	endtask
endmodule // albi_far_model

// File: tb/albi_label_bus_tb.sv
`timescale 1ns/1ps
module albi_label_bus_tb;
	import albi_pkg::*;
	localparam int          SER_DIV_T = 16;
	localparam logic [31:0] FULL      = 32'hffffffff;
	logic        clk;
	logic        rst_b;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic        regWr;
	logic        regRd;
	logic [31:0] regRdata;
	logic        serRx;
	logic        serTx;
	logic [3:0]  rxHi;
	logic [3:0]  rxLo;
	logic        txHi;
	logic        txLo;
	int          failCount;
	int          numChecks;
	logic [31:0] txSeen;

	albi_label_bus #(.SER_DIV_P(SER_DIV_T), .FRAME_CYC_P(20000)) i_albi_label_bus (
		.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .serRx(serRx), .serTx(serTx), .rxHi(rxHi), .rxLo(rxLo), .txHi(txHi), .txLo(txLo)
	);
	albi_far_model #(.BIT_CYC(BIT_HI_CYC), .SER_DIV(SER_DIV_T)) i_albi_far_model (
		.clk(clk), .rxHi(rxHi), .rxLo(rxLo), .serRx(serRx), .txHi(txHi), .txLo(txLo)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic finalReport();
		if (failCount == 0 && numChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		numChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// answer stands only in the cycle after the strobe
	task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk(name, exp, regRdata & m);
	endtask

	// label goes out msb first in bits 1..8, odd parity on top
	function automatic logic [31:0] mkWord(input logic [7:0] lbl, input logic [22:0] d);
		logic [31:0] w;
		for (int i = 0; i < 8; i++) begin
			w[i] = lbl[7 - i];
		end
		w[30:8] = d;
		w[31] = ~^w[30:0];
		return w;
	endfunction

	initial begin
		repeat (90000) @(posedge clk);
		chk("watchdog", 32'h1, 32'h0);
		finalReport();
	end

	initial begin
		rst_b = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		failCount = 0;
		numChecks = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rdChk("ctrl", REG_CTRL, 32'h0, FULL);
		rdChk("stat", REG_STAT, 32'h0, FULL);
		rdChk("unmapped", 8'hfc, 32'h0, FULL);
		wr(REG_STAT, FULL);
		rdChk("statRo", REG_STAT, 32'h0, FULL);
		wr(REG_CTRL, FULL);
		rdChk("ctrlAll", REG_CTRL, 32'h1fff, FULL);
		wr(REG_AIR_BASE + 8'h08, 32'h1234abcd);
		rdChk("turnItem", REG_AIR_BASE + 8'h08, 32'habcd, FULL);
		wr(REG_CTRL, 32'h7e2);
		wr(REG_TXW_BASE + 8'h18, 32'h2a5a5a);
		i_albi_far_model.sendByte(8'ha5);
		i_albi_far_model.sendByte(8'h3c);
		i_albi_far_model.sendByte(8'h0f);
		repeat (4 * SER_DIV_T) @(posedge clk);
		rdChk("serFull", REG_SER_STAT, 32'h600, 32'h700);
		rdChk("serByte0", REG_SER_DATA, 32'h1a5, 32'h1ff);
		rdChk("serByte1", REG_SER_DATA, 32'h13c, 32'h1ff);
		rdChk("serEmpty", REG_SER_DATA, 32'h0, 32'h100);
		rdChk("serDrained", REG_SER_STAT, 32'h0, 32'h700);
		// standard profile: framed, seven data bits kept
		wr(REG_CTRL, 32'h7e0);
		i_albi_far_model.sendByte(STX);
		i_albi_far_model.sendByte(8'hc1);
		i_albi_far_model.sendByte(ETX);
		repeat (4 * SER_DIV_T) @(posedge clk);
		rdChk("pktStat", REG_SER_STAT, 32'h201, 32'h7ff);
		rdChk("pktByte0", REG_SER_DATA, 32'h141, 32'h1ff);
		rdChk("pktByte1", REG_SER_DATA, 32'h103, 32'h1ff);
		// no coupler: the first frame sends only the heading label
		fork
			i_albi_far_model.sendWord(2'd0, mkWord(LBL_MODE, 23'h000001));
			i_albi_far_model.sendWord(2'd2, mkWord(LBL_FREQ, 23'h0a5a35));
			i_albi_far_model.recvWord(txSeen);
		join
		chk("txWord", mkWord(8'hd0, 23'h2a5a5a), txSeen);
		rdChk("statHoldLoc", REG_STAT, 32'h11, FULL);
		rdChk("freq", REG_RXP_BASE + 8'h30, 32'h0a5a35, FULL);
		fork
			i_albi_far_model.sendWord(2'd1, mkWord(LBL_SRC, 23'h000010));
			i_albi_far_model.sendWord(2'd3, mkWord(8'h7b, 23'h7f0001));
		join
		rdChk("statSrc", REG_STAT, 32'h19, FULL);
		rdChk("locDev", REG_RXP_BASE + 8'h34, 32'h7f0001, FULL);
		fork
			i_albi_far_model.sendWord(2'd0, mkWord(8'h77, 23'h7fffff));
			i_albi_far_model.sendWord(2'd1, mkWord(LBL_TOFR, 23'h004000));
		join
		rdChk("statTo", REG_STAT, 32'h1b, FULL);
		rdChk("freqKept", REG_RXP_BASE + 8'h30, 32'h0a5a35, FULL);
		for (int s = 0; s < 12; s++) begin
			rdChk("gpsSlot", REG_RXP_BASE + 8'(4 * s), 32'h0, FULL);
		end
		// air data packet only at the one-second mark, beyond this run
		chk("serIdle", 32'h1, {31'h0, serTx});
		finalReport();
	end
endmodule // albi_label_bus_tb
